// file: verilog/rsqf_pkg.sv
`default_nettype none
package rsqf_pkg;

    // ----------------------------------------------------------------
    // Register map and field layout
    // ----------------------------------------------------------------
    localparam int AXI_AW = 8;
    localparam logic [AXI_AW-1:0] REG_STATUS_OFS = 8'h00;
    localparam logic [AXI_AW-1:0] REG_TRIM_HI_OFS = 8'h04;
    localparam int STAT_TRIM_LSB = 5;
    localparam int STAT_WDGF_BIT = 4;
    localparam int STAT_LOCK_BIT = 3;
    localparam int STAT_LVDF_BIT = 2;
    localparam logic [1:0] TRIM_LO_RST = 2'h3;
    localparam logic [7:0] TRIM_HI_RST = 8'hFF;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ----------------------------------------------------------------
    // Sequence figures
    // ----------------------------------------------------------------
    localparam int CNT_W = 16;
    localparam int CLK_PERIOD_NS = 100;
    localparam int DLY_SHORT_CYC = 256;
    localparam int DLY_LONG_CYC = 4096;
    localparam int FETCH_CYC = 2;
    localparam logic [15:0] VEC_LO_ADDR = 16'hFFFE;
    localparam logic [15:0] VEC_HI_ADDR = 16'hFFFF;

    // Synchronised level inputs, by index
    localparam int SY_LVD = 0;
    localparam int SY_LOCK = 1;
    localparam int SY_XTAL = 2;
    localparam int SY_PLLEN = 3;
    localparam int SY_LVDEN = 4;
    localparam int SY_N = 5;

    typedef enum logic [4:0] {
        RSQF_RUN = 5'h01,
        RSQF_ACTIVE = 5'h02,
        RSQF_PLL = 5'h04,
        RSQF_DELAY = 5'h08,
        RSQF_FETCH = 5'h10
    } rsqf_state_t;

endpackage
`default_nettype wire

// file: verilog/rsqf_top.sv
// Overview of operation
// - Pin, low voltage or watchdog resets device
// - Illegal opcode starts full reset
// - Phases: active, fixed delay, vector fetch
// - Delay 256 cycles, 4096 with crystal
// - Vector fetch lasts exactly two cycles
// - Vector always fetched from top pair
// - Multiplier enabled adds start-up clock hold
// - Pin driven low through whole delay
// - Pin is input plus open-drain output
// - Pin low caught without running clock
// - Undervoltage holds reset and drives pin
// - Low voltage source ignored unless enabled
// - Watchdog drives pin for minimum width
// - Crystal oscillator keeps running in reset
// - Status frozen in halt, normal in wait
// - Status resets to trim ones, reserved zero
// - Status bits 6:5 are trim low bits
// - Watchdog flag set by watchdog, cleared by undervoltage or a zero write
// - Two flags encode the reset cause
// - Lock flag follows multiplier lock, hardware only
// - Voltage flag set by undervoltage, read clears
// - Voltage flag survives later pin/watchdog resets
//
// Implementation choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module rsqf_top #(
    parameter int PLL_STARTUP_NS = 1000000,
    parameter int WDG_OUT_NS = 30000
) (
    input wire logic mclk_i, // CPU clock
    input wire logic resetn_i, // Power-on reset, async
    input wire logic rst_pin_i, // Reset pad level
    output logic rst_pin_o, // Reset pad drive value
    output logic rst_pin_oe_o, // Reset pad pull-down enable
    input wire logic lvd_i, // Undervoltage level
    input wire logic lvd_en_i, // Option: detector enabled
    input wire logic xtal_sel_i, // Option: crystal clock source
    input wire logic pll_en_i, // Option: multiplier enabled
    input wire logic pll_lock_i, // Multiplier locked level
    input wire logic wdg_uflow_i, // Watchdog underflow pulse
    input wire logic illegal_op_i, // Illegal opcode pulse
    input wire logic halt_i, // Halt mode level
    output logic cpu_reset_o, // Core held in reset
    output logic vec_fetch_o, // Vector fetch cycle
    output logic [15:0] vec_addr_o, // Vector byte address
    output logic clk_hold_o, // System clock withheld
    output logic osc_en_o, // Oscillator enable
    output logic [9:0] trim_o, // Oscillator trim value
    input wire logic [rsqf_pkg::AXI_AW-1:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [rsqf_pkg::AXI_AW-1:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready // Read data ready
);
    import rsqf_pkg::*;

    // ----------------------------------------------------------------
    // Derived cycle counts
    // ----------------------------------------------------------------
    localparam int PLL_CYC_RAW = (PLL_STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PLL_CYC = (PLL_CYC_RAW < 1) ? 1 : PLL_CYC_RAW;
    localparam int WDG_CYC_RAW = (WDG_OUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WDG_CYC = (WDG_CYC_RAW < 1) ? 1 : WDG_CYC_RAW;

    generate
        if (PLL_CYC >= (1 << CNT_W) || WDG_CYC >= (1 << CNT_W)) begin : g_bad
            $error("rsqf_top: start-up or watchdog width exceeds counter");
        end
    endgenerate

    typedef struct packed {
        rsqf_state_t st;
        logic [CNT_W-1:0] cnt;
        logic src_wdg;
        logic drive;
        logic drive_q;
        logic cpu_rst;
        logic fetch;
        logic [15:0] vaddr;
        logic osc_en;
        logic hold;
        logic [SY_N-1:0] s1;
        logic [SY_N-1:0] s2;
        logic [SY_N-1:0] s3;
        logic [SY_N-1:0] lv;
        logic [1:0] trim_lo;
        logic [7:0] trim_hi;
        logic watchdog_cause_flag;
        logic voltage_cause_flag;
        logic locked;
        logic aw_have;
        logic [AXI_AW-1:0] aw_addr;
        logic w_have;
        logic [7:0] wdata;
        logic wstrb0;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [7:0] rdata;
    } rsqf_regs_t;

    rsqf_regs_t r_reg;
    rsqf_regs_t r_next;

    // ----------------------------------------------------------------
    // Asynchronous reset catch
    // ----------------------------------------------------------------
    // Own pull-down masked until one cycle past release: the pad rises
    // after the drive drops, so a shorter mask would retrigger the catch
    logic req_async;
    logic [2:0] req_sync_reg;
    assign req_async = ~resetn_i | (lvd_i & lvd_en_i)
        | (~rst_pin_i & ~(r_reg.drive | r_reg.drive_q));

    always_ff @(posedge mclk_i or posedge req_async) begin
        if (req_async) begin
            req_sync_reg <= 3'h7;
        end else begin
            req_sync_reg <= {req_sync_reg[1:0], 1'b0};
        end
    end

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    logic [7:0] stat_val;
    logic aw_hs;
    logic w_hs;
    logic ar_hs;
    logic lvd_act;
    logic go_active;
    logic go_wdg;

    always_comb begin
        r_next = r_reg;
        go_active = 1'b0;
        go_wdg = 1'b0;
        stat_val = 8'h00;
        stat_val[STAT_TRIM_LSB +: 2] = r_reg.trim_lo;
        stat_val[STAT_WDGF_BIT] = r_reg.watchdog_cause_flag;
        stat_val[STAT_LOCK_BIT] = r_reg.locked;
        stat_val[STAT_LVDF_BIT] = r_reg.voltage_cause_flag;
        aw_hs = s_axi_awvalid & r_reg.awready;
        w_hs = s_axi_wvalid & r_reg.wready;
        ar_hs = s_axi_arvalid & r_reg.arready;
        lvd_act = r_reg.lv[SY_LVD] & r_reg.lv[SY_LVDEN];

        // Level inputs: three stages, accept once stages two and three agree
        r_next.s1 = {lvd_en_i, pll_en_i, xtal_sel_i, pll_lock_i, lvd_i};
        r_next.s2 = r_reg.s1;
        r_next.s3 = r_reg.s2;
        r_next.lv = (r_reg.s2 & r_reg.s3) | (r_reg.lv & (r_reg.s2 | r_reg.s3));
        r_next.drive_q = r_reg.drive;
        if (req_sync_reg[1] == req_sync_reg[2]) begin
            r_next.hold = req_sync_reg[2];
        end

        // Write channel
        if (aw_hs) begin
            r_next.aw_have = 1'b1;
            r_next.aw_addr = s_axi_awaddr;
            r_next.awready = 1'b0;
        end
        if (w_hs) begin
            r_next.w_have = 1'b1;
            r_next.wdata = s_axi_wdata[7:0];
            r_next.wstrb0 = s_axi_wstrb[0];
            r_next.wready = 1'b0;
        end
        if (r_reg.aw_have && r_reg.w_have && !r_reg.bvalid) begin
            r_next.bvalid = 1'b1;
            r_next.bresp = RESP_OKAY;
            if (r_reg.aw_addr == REG_STATUS_OFS) begin
                if (r_reg.wstrb0 && !halt_i) begin
                    r_next.trim_lo = r_reg.wdata[STAT_TRIM_LSB +: 2];
                    if (!r_reg.wdata[STAT_WDGF_BIT]) begin
                        r_next.watchdog_cause_flag = 1'b0;
                    end
                end
            end else if (r_reg.aw_addr == REG_TRIM_HI_OFS) begin
                if (r_reg.wstrb0) begin
                    r_next.trim_hi = r_reg.wdata;
                end
            end else begin
                r_next.bresp = RESP_SLVERR;
            end
        end
        if (r_reg.bvalid && s_axi_bready) begin
            r_next.bvalid = 1'b0;
            r_next.aw_have = 1'b0;
            r_next.w_have = 1'b0;
            r_next.awready = 1'b1;
            r_next.wready = 1'b1;
        end

        // Read channel
        if (ar_hs) begin
            r_next.arready = 1'b0;
            r_next.rvalid = 1'b1;
            r_next.rresp = RESP_OKAY;
            if (s_axi_araddr == REG_STATUS_OFS) begin
                r_next.rdata = stat_val;
                if (!halt_i) begin
                    r_next.voltage_cause_flag = 1'b0;
                end
            end else if (s_axi_araddr == REG_TRIM_HI_OFS) begin
                r_next.rdata = r_reg.trim_hi;
            end else begin
                r_next.rdata = 8'h00;
                r_next.rresp = RESP_SLVERR;
            end
        end
        if (r_reg.rvalid && s_axi_rready) begin
            r_next.rvalid = 1'b0;
            r_next.arready = 1'b1;
        end

        if (!halt_i) begin
            r_next.locked = r_reg.lv[SY_LOCK];
        end

        // ------------------------------------------------------------
        // Reset sequence
        // ------------------------------------------------------------
        case (r_reg.st)
            RSQF_RUN: begin
                if (r_reg.hold) begin
                    go_active = 1'b1;
                end else if (wdg_uflow_i || illegal_op_i) begin
                    go_active = 1'b1;
                    go_wdg = wdg_uflow_i;
                end
            end
            RSQF_ACTIVE: begin
                r_next.drive = lvd_act | r_reg.src_wdg;
                if (r_reg.hold) begin
                    r_next.cnt = r_reg.cnt;
                end else if (r_reg.src_wdg && r_reg.cnt != '0) begin
                    r_next.cnt = r_reg.cnt - 1'b1;
                end else if (r_reg.lv[SY_PLLEN]) begin
                    r_next.st = RSQF_PLL;
                    r_next.cnt = CNT_W'(PLL_CYC - 1);
                    r_next.drive = 1'b1;
                end else begin
                    r_next.st = RSQF_DELAY;
                    r_next.drive = 1'b1;
                    r_next.cnt = r_reg.lv[SY_XTAL] ? CNT_W'(DLY_LONG_CYC - 1)
                                                    : CNT_W'(DLY_SHORT_CYC - 1);
                end
            end
            RSQF_PLL: begin
                if (r_reg.hold) begin
                    go_active = 1'b1;
                end else if (r_reg.cnt != '0) begin
                    r_next.cnt = r_reg.cnt - 1'b1;
                end else begin
                    r_next.st = RSQF_DELAY;
                    r_next.cnt = r_reg.lv[SY_XTAL] ? CNT_W'(DLY_LONG_CYC - 1)
                                                    : CNT_W'(DLY_SHORT_CYC - 1);
                end
            end
            RSQF_DELAY: begin
                r_next.drive = 1'b1;
                if (r_reg.hold) begin
                    go_active = 1'b1;
                end else if (r_reg.cnt != '0) begin
                    r_next.cnt = r_reg.cnt - 1'b1;
                end else begin
                    r_next.st = RSQF_FETCH;
                    r_next.drive = 1'b0;
                    r_next.fetch = 1'b1;
                    r_next.vaddr = VEC_LO_ADDR;
                    r_next.cnt = CNT_W'(FETCH_CYC - 1);
                end
            end
            RSQF_FETCH: begin
                if (r_reg.hold) begin
                    go_active = 1'b1;
                end else if (r_reg.cnt != '0) begin
                    r_next.cnt = r_reg.cnt - 1'b1;
                    r_next.vaddr = VEC_HI_ADDR;
                end else begin
                    r_next.st = RSQF_RUN;
                    r_next.fetch = 1'b0;
                    r_next.cpu_rst = 1'b0;
                end
            end
            default: begin
                go_active = 1'b1;
            end
        endcase

        if (go_active) begin
            r_next.st = RSQF_ACTIVE;
            r_next.cpu_rst = 1'b1;
            r_next.fetch = 1'b0;
            r_next.src_wdg = go_wdg;
            r_next.drive = go_wdg;
            r_next.cnt = go_wdg ? CNT_W'(WDG_CYC - 1) : '0;
            r_next.trim_lo = TRIM_LO_RST;
            r_next.trim_hi = TRIM_HI_RST;
        end

        // Hardware sets last so they win over a same-cycle clear
        // watchdog flag set
        if (go_wdg) begin
            r_next.watchdog_cause_flag = 1'b1;
        end
        if (lvd_act) begin
            r_next.voltage_cause_flag = 1'b1;
            r_next.watchdog_cause_flag = 1'b0;
        end

        r_next.osc_en = (r_next.st != RSQF_RUN) | ~halt_i;
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            r_reg <= '0;
            r_reg.st <= RSQF_ACTIVE;
            r_reg.cpu_rst <= 1'b1;
            r_reg.osc_en <= 1'b1;
            r_reg.hold <= 1'b1;
            r_reg.trim_lo <= TRIM_LO_RST;
            r_reg.trim_hi <= TRIM_HI_RST;
            r_reg.awready <= 1'b1;
            r_reg.wready <= 1'b1;
            r_reg.arready <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    assign rst_pin_o = 1'b0;
    assign rst_pin_oe_o = r_reg.drive;
    assign cpu_reset_o = r_reg.cpu_rst;
    assign vec_fetch_o = r_reg.fetch;
    assign vec_addr_o = r_reg.vaddr;
    assign clk_hold_o = r_reg.st[2];
    assign osc_en_o = r_reg.osc_en;
    assign trim_o = {r_reg.trim_hi, r_reg.trim_lo};
    assign s_axi_awready = r_reg.awready;
    assign s_axi_wready = r_reg.wready;
    assign s_axi_bresp = r_reg.bresp;
    assign s_axi_bvalid = r_reg.bvalid;
    assign s_axi_arready = r_reg.arready;
    assign s_axi_rdata = {24'h000000, r_reg.rdata};
    assign s_axi_rresp = r_reg.rresp;
    assign s_axi_rvalid = r_reg.rvalid;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);

    logic [CNT_W-1:0] dly_len_reg;
    logic [CNT_W-1:0] dly_tgt;
    logic wdg_start;
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            dly_len_reg <= '0;
        end else if (r_reg.st == RSQF_DELAY) begin
            dly_len_reg <= dly_len_reg + 1'b1;
        end else begin
            dly_len_reg <= '0;
        end
    end
    assign dly_tgt = r_reg.lv[SY_XTAL] ? CNT_W'(DLY_LONG_CYC - 1) : CNT_W'(DLY_SHORT_CYC - 1);
    assign wdg_start = (r_reg.st == RSQF_RUN) && !r_reg.hold && wdg_uflow_i;

    sequence fetch_lo_s;
        vec_fetch_o && vec_addr_o == VEC_LO_ADDR && cpu_reset_o;
    endsequence
    sequence fetch_hi_s;
        vec_fetch_o && vec_addr_o == VEC_HI_ADDR && cpu_reset_o;
    endsequence

    a_delay_length: assert property (
        $rose(vec_fetch_o) |-> $past(dly_len_reg) == $past(dly_tgt))
        else $error("delay phase length wrong");
    a_fetch_two_cycles: assert property (
        $rose(vec_fetch_o) && !r_reg.hold |-> fetch_lo_s ##1 fetch_hi_s)
        else $error("vector fetch not two cycles");
    a_fetch_release: assert property (
        vec_fetch_o && vec_addr_o == VEC_HI_ADDR && !r_reg.hold |=> !vec_fetch_o && !cpu_reset_o)
        else $error("reset not released after fetch");
    a_delay_drives_pin: assert property (
        (r_reg.st == RSQF_DELAY) |-> rst_pin_oe_o && cpu_reset_o)
        else $error("pin not driven during delay");
    a_wdg_pin_width: assert property (wdg_start |=> rst_pin_oe_o [*8])
        else $error("watchdog pulse too short");
    a_wdg_flag_set: assert property (wdg_start && !lvd_act |=> r_reg.watchdog_cause_flag)
        else $error("watchdog flag not set");
    a_lvd_holds_reset: assert property (
        lvd_act |-> ##[1:4] (cpu_reset_o && rst_pin_oe_o && r_reg.voltage_cause_flag))
        else $error("undervoltage not holding reset");
    a_lvd_read_clear: assert property (
        ar_hs && s_axi_araddr == REG_STATUS_OFS && !halt_i && !lvd_act |=> !r_reg.voltage_cause_flag)
        else $error("voltage flag not cleared by read");
    a_halt_freeze: assert property (
        halt_i && r_reg.st == RSQF_RUN && !r_reg.hold && !wdg_uflow_i && !illegal_op_i
        |=> $stable(trim_o[1:0]) && $stable(r_reg.locked))
        else $error("status changed in halt");
    a_pll_hold_first: assert property (
        $rose(clk_hold_o) |-> r_reg.lv[SY_PLLEN] && !vec_fetch_o)
        else $error("clock hold without multiplier");

endmodule
`default_nettype wire

// file: verification/rsqf_pad_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Reset pad with external pull-down source
// ----------------------------------------------------------------
module rsqf_pad_model (
    input wire logic mclk_i, // Bench clock
    input wire logic pull_start_i, // Start an external low pulse
    input wire logic [7:0] pull_cycles_i, // Pulse length in cycles
    input wire logic dev_drive_i, // Device drive value
    input wire logic dev_oe_i, // Device pull-down enable
    output logic pad_o // Resolved pad level
);
    logic [7:0] left_reg = 8'h00;

    assign pad_o = ((dev_oe_i && !dev_drive_i) || left_reg != 8'h00) ? 1'b0 : 1'b1;

    // Length is a port so slow and brief pulls both reach the pad
    always @(posedge mclk_i) begin
        if (pull_start_i) begin
            left_reg <= pull_cycles_i;
        end else if (left_reg != 8'h00) begin
            left_reg <= left_reg - 8'h01;
        end
    end
endmodule
`default_nettype wire

// file: verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import rsqf_pkg::*;
    logic mclk_i = 1'b0, resetn_i = 1'b0, lvd_i = 1'b0, lvd_en_i = 1'b0, xtal_sel_i = 1'b0;
    logic pll_en_i = 1'b0, pll_lock_i = 1'b0, wdg_uflow_i = 1'b0, illegal_op_i = 1'b0;
    logic halt_i = 1'b0, awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
    logic pull_start = 1'b0;
    logic rst_pin_i, rst_pin_o, rst_pin_oe_o, cpu_reset_o, vec_fetch_o, clk_hold_o, osc_en_o;
    logic awr, wr, bv, arr, rv;
    logic [15:0] vec_addr_o;
    logic [9:0] trim_o;
    logic [9:0] r;
    logic [AXI_AW-1:0] awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0;
    logic [31:0] rd;
    logic [1:0] bresp, rresp;
    logic [33:0] exp_q[$];
    int err_count = 0;
    int check_count = 0;

    always #50 mclk_i = ~mclk_i;

    rsqf_top #(.PLL_STARTUP_NS(2000), .WDG_OUT_NS(1500)) u_dut (
        .mclk_i(mclk_i), .resetn_i(resetn_i), .rst_pin_i(rst_pin_i), .rst_pin_o(rst_pin_o),
        .rst_pin_oe_o(rst_pin_oe_o), .lvd_i(lvd_i), .lvd_en_i(lvd_en_i), .xtal_sel_i(xtal_sel_i),
        .pll_en_i(pll_en_i), .pll_lock_i(pll_lock_i), .wdg_uflow_i(wdg_uflow_i),
        .illegal_op_i(illegal_op_i), .halt_i(halt_i), .cpu_reset_o(cpu_reset_o),
        .vec_fetch_o(vec_fetch_o), .vec_addr_o(vec_addr_o), .clk_hold_o(clk_hold_o),
        .osc_en_o(osc_en_o), .trim_o(trim_o), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'h1), .s_axi_wvalid(wv),
        .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
        .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr));

    rsqf_pad_model u_pad (.mclk_i(mclk_i), .pull_start_i(pull_start), .pull_cycles_i(8'h0A),
        .dev_drive_i(rst_pin_o), .dev_oe_i(rst_pin_oe_o), .pad_o(rst_pin_i));

    // ----------------------------------------------------------------
    // Checking and closing
    // ----------------------------------------------------------------
    task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
        check_count++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            err_count++;
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic fail_wait(input string nm);
        $display("wrong value %s expected done seen timeout", nm);
        err_count++;
        print_verdict();
    endtask

    // Oldest note is compared whenever a read answer is taken
    always @(negedge mclk_i) begin
        if (rv === 1'b1 && rr === 1'b1) begin
            chk("read resp and data", exp_q.pop_front(), {rresp, rd});
        end
    end

    // ----------------------------------------------------------------
    // Register bus master
    // ----------------------------------------------------------------
    // Readies sampled mid-cycle, where they stand for the coming edge
    task automatic axi_wr(input logic [7:0] a, input logic [7:0] d);
        int n;
        logic a_t;
        logic w_t;
        logic b_t;
        logic [1:0] b_r;
        @(posedge mclk_i);
        awa <= a;
        wd <= {24'h0, d};
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(negedge mclk_i);
            a_t = awr;
            w_t = wr;
            b_t = bv;
            b_r = bresp;
            @(posedge mclk_i);
            if (awv && a_t === 1'b1) awv <= 1'b0;
            if (wv && w_t === 1'b1) wv <= 1'b0;
            if (b_t === 1'b1) break;
        end
        br <= 1'b0;
        chk("write response", RESP_OKAY, b_r);
        if (n == 40) fail_wait("write");
    endtask

    task automatic axi_rd(input logic [7:0] a, input logic [1:0] rs, input logic [7:0] v);
        int n;
        logic a_t;
        logic r_t;
        @(posedge mclk_i);
        exp_q.push_back({rs, 24'h0, v});
        ara <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(negedge mclk_i);
            a_t = arr;
            r_t = rv;
            @(posedge mclk_i);
            if (arv && a_t === 1'b1) arv <= 1'b0;
            if (r_t === 1'b1) break;
        end
        rr <= 1'b0;
        if (n == 40) fail_wait("read");
    endtask

    // ----------------------------------------------------------------
    // Reset sequence observer: hold, pad drive, vector fetch
    // ----------------------------------------------------------------
    task automatic seq(input string nm, input int eh, input int eo, input bit ex);
        int n;
        int h;
        int o;
        int f;
        logic [31:0] ad;
        logic lf;
        h = 0;
        o = 0;
        f = 0;
        ad = 32'h0;
        lf = 1'b0;
        // Sampled mid-cycle so each counted cycle shows settled outputs
        @(negedge mclk_i);
        for (n = 0; n < 8 && cpu_reset_o !== 1'b1; n++) @(negedge mclk_i);
        for (n = 0; n < 9000 && cpu_reset_o === 1'b1; n++) begin
            lf = vec_fetch_o;
            h += (clk_hold_o === 1'b1);
            o += (rst_pin_oe_o === 1'b1 && clk_hold_o !== 1'b1);
            if (vec_fetch_o === 1'b1) begin
                ad = {ad[15:0], vec_addr_o};
                f++;
            end
            @(negedge mclk_i);
        end
        if (n == 9000) fail_wait(nm);
        @(posedge mclk_i);
        chk("hold cycles", eh, h);
        chk("drive cycles", ex ? eo : 1, ex ? o : (o >= eo));
        chk("fetch count", FETCH_CYC, f);
        chk("fetch addresses", {VEC_LO_ADDR, VEC_HI_ADDR}, ad);
        chk("fetch ends reset", 1'b1, lf);
        $display("test %s done", nm);
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(37));
        repeat (20) @(posedge mclk_i);
        resetn_i <= 1'b1;
        seq("power-up", 0, DLY_SHORT_CYC, 1'b0);
        axi_rd(REG_STATUS_OFS, RESP_OKAY, 8'h60);
        axi_rd(REG_TRIM_HI_OFS, RESP_OKAY, TRIM_HI_RST);
        axi_rd(8'h08, RESP_SLVERR, 8'h00);
        r = 10'($urandom);
        axi_wr(REG_TRIM_HI_OFS, r[9:2]);
        axi_wr(REG_STATUS_OFS, {1'b0, r[1:0], 5'h1F});
        axi_rd(REG_STATUS_OFS, RESP_OKAY, {1'b0, r[1:0], 5'h00});
        chk("trim value", r, trim_o);
        halt_i <= 1'b1;
        axi_wr(REG_STATUS_OFS, {1'b0, ~r[1:0], 5'h00});
        axi_rd(REG_STATUS_OFS, RESP_OKAY, {1'b0, r[1:0], 5'h00});
        halt_i <= 1'b0;
        $display("test registers done");
        wdg_uflow_i <= 1'b1;
        @(posedge mclk_i);
        wdg_uflow_i <= 1'b0;
        seq("watchdog", 0, 15 + DLY_SHORT_CYC, 1'b0);
        axi_rd(REG_STATUS_OFS, RESP_OKAY, 8'h70);
        axi_wr(REG_STATUS_OFS, 8'h60);
        axi_rd(REG_STATUS_OFS, RESP_OKAY, 8'h60);
        lvd_en_i <= 1'b1;
        lvd_i <= 1'b1;
        repeat (30) @(posedge mclk_i);
        chk("held reset, pad, osc", 3'b111, {cpu_reset_o, rst_pin_oe_o, osc_en_o});
        lvd_i <= 1'b0;
        seq("undervoltage", 0, DLY_SHORT_CYC, 1'b0);
        pull_start <= 1'b1;
        @(posedge mclk_i);
        pull_start <= 1'b0;
        seq("pad pulse", 0, DLY_SHORT_CYC, 1'b1);
        axi_rd(REG_STATUS_OFS, RESP_OKAY, 8'h64);
        axi_rd(REG_STATUS_OFS, RESP_OKAY, 8'h60);
        lvd_en_i <= 1'b0;
        repeat (10) @(posedge mclk_i);
        lvd_i <= 1'b1;
        repeat (20) @(posedge mclk_i);
        chk("reset ignored", 1'b0, cpu_reset_o);
        lvd_i <= 1'b0;
        xtal_sel_i <= 1'b1;
        pll_en_i <= 1'b1;
        repeat (5) @(posedge mclk_i);
        illegal_op_i <= 1'b1;
        @(posedge mclk_i);
        illegal_op_i <= 1'b0;
        seq("illegal opcode", 20, DLY_LONG_CYC, 1'b1);
        pll_lock_i <= 1'b1;
        repeat (5) @(posedge mclk_i);
        axi_rd(REG_STATUS_OFS, RESP_OKAY, 8'h68);
        print_verdict();
    end
endmodule
`default_nettype wire
